/* File: rtl/clsm_top.sv */
// Decided for this implementation: the strobed register port and the register addresses.
`timescale 1ns/1ps
`include "clsm_consts.svh"
module clsm_top #(
  parameter int TICK_CYC = `CLSM_TICK_CYC
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [7:0] addr,
  input wire logic [31:0] wr_data,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [31:0] rd_data,
  input wire logic local_run,
  input wire logic local_err,
  input wire logic peer_evt,
  input wire logic [1:0] peer_link,
  input wire logic [5:0] peer_entry,
  input wire logic peer_done,
  input wire logic peer_run,
  input wire logic peer_err,
  input wire logic peer_chain_ok,
  output logic [3:0] overall_run_link_flag,
  output logic [3:0] link_trouble_flag
);
  // ---------------------------------------------------------------
  // Shared millisecond tick
  // ---------------------------------------------------------------
  logic tick;

  clsm_tick #(.TICK_CYC(TICK_CYC)) u_tick (
    .mclk(mclk),
    .rst_n(rst_n),
    .tick(tick)
  );

  // ---------------------------------------------------------------
  // Software registers
  // ---------------------------------------------------------------
  logic [7:0] ctrl_r, ctrl_nxt;
  logic [31:0] per_last_r, per_last_nxt;
  clsm_pkg::clsm_bits_t mask_r [`CLSM_NLINK];
  clsm_pkg::clsm_bits_t mask_nxt [`CLSM_NLINK];
  logic [3:0] link_en, list_valid;
  logic per_wr;
  clsm_pkg::clsm_ms_t per_raw, per_clamp;

  assign link_en = ctrl_r[`CLSM_CTRL_EN_LSB +: 4];
  assign list_valid = ctrl_r[`CLSM_CTRL_VALID_LSB +: 4];
  assign per_wr = wr_stb && (addr == `CLSM_ADDR_PERIOD);
  assign per_raw = wr_data[`CLSM_PER_MS_LSB +: 14];

  // Out-of-range periods are pulled into the legal window on write
  always_comb begin
    if (per_raw == 14'h0000) begin
      per_clamp = `CLSM_PER_DEF_MS; // [R12]
    end else if (per_raw < `CLSM_PER_MIN_MS) begin
      per_clamp = `CLSM_PER_MIN_MS; // [R12]
    end else if (per_raw > `CLSM_PER_MAX_MS) begin
      per_clamp = `CLSM_PER_MAX_MS; // [R12]
    end else begin
      per_clamp = per_raw;
    end
  end

  always_comb begin
    ctrl_nxt = ctrl_r;
    per_last_nxt = per_last_r;
    for (int l = 0; l < `CLSM_NLINK; l++) begin
      mask_nxt[l] = mask_r[l];
    end
    if (wr_stb) begin
      if (addr == `CLSM_ADDR_CTRL) begin
        ctrl_nxt = wr_data[7:0];
      end else if (addr == `CLSM_ADDR_PERIOD) begin
        per_last_nxt = {2'h0, per_clamp, 8'h00, wr_data[7:0]};
      end else if (addr >= `CLSM_ADDR_MASK_BASE &&
                   addr <= `CLSM_ADDR_MASK_LAST) begin
        if (addr[2]) begin
          mask_nxt[addr[4:3]][63:32] = wr_data;
        end else begin
          mask_nxt[addr[4:3]][31:0] = wr_data;
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= `CLSM_CTRL_RST;
      per_last_r <= 32'h0000_0000;
      for (int l = 0; l < `CLSM_NLINK; l++) begin
        mask_r[l] <= 64'h0;
      end
    end else begin
      ctrl_r <= ctrl_nxt;
      per_last_r <= per_last_nxt;
      for (int l = 0; l < `CLSM_NLINK; l++) begin
        mask_r[l] <= mask_nxt[l];
      end
    end
  end

  // ---------------------------------------------------------------
  // Link instances
  // ---------------------------------------------------------------
  clsm_pkg::clsm_bits_t trx_w [`CLSM_NLINK];
  clsm_pkg::clsm_bits_t run_w [`CLSM_NLINK];
  clsm_pkg::clsm_bits_t err_w [`CLSM_NLINK];
  clsm_pkg::clsm_bits_t hlt_w [`CLSM_NLINK];
  logic [3:0] all_ok;

  for (genvar l = 0; l < `CLSM_NLINK; l++) begin : g_link
    clsm_link_if lif ();

    assign lif.en = link_en[l];
    assign lif.evt = peer_evt && (peer_link == 2'(l)); // [R11]
    assign lif.eidx = peer_entry;
    assign lif.done = peer_done;
    assign lif.prun = peer_run;
    assign lif.perr = peer_err;
    assign lif.pchain = peer_chain_ok;
    assign lif.pwr = per_wr &&
      (wr_data[`CLSM_PER_LINK_LSB +: 2] == 2'(l));
    assign lif.pidx = wr_data[`CLSM_PER_ENTRY_LSB +: 6];
    assign lif.pms = per_clamp;
    assign lif.mask = mask_r[l];
    assign trx_w[l] = lif.trx;
    assign run_w[l] = lif.run;
    assign err_w[l] = lif.err;
    assign hlt_w[l] = lif.hlt;
    // Each configured entry must be healthy with its peer's list sound
    assign all_ok[l] = &(~mask_r[l] | (lif.hlt & lif.chain)); // [R2] [R4]

    clsm_link u_link (
      .mclk(mclk),
      .rst_n(rst_n),
      .tick(tick),
      .lif(lif)
    );
  end

  // ---------------------------------------------------------------
  // Run-link and link-trouble
  // ---------------------------------------------------------------
  logic [3:0] rlink_r, rlink_nxt, ltrbl_r, ltrbl_nxt;
  logic local_ok;

  assign local_ok = local_run && !local_err; // [R3]

  // Sticky: later faults cannot clear it, only dropping enable does
  always_comb begin
    rlink_nxt = link_en & (rlink_r | (list_valid & all_ok & // [R1] [R5]
      {4{local_ok}})); // [R3]
    ltrbl_nxt = ~rlink_nxt; // [R6]
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rlink_r <= 4'h0;
      ltrbl_r <= 4'hf;
    end else begin
      rlink_r <= rlink_nxt;
      ltrbl_r <= ltrbl_nxt;
    end
  end

  assign overall_run_link_flag = rlink_r;
  assign link_trouble_flag = ltrbl_r;

  // ---------------------------------------------------------------
  // Read port
  // ---------------------------------------------------------------
  logic [31:0] rd_data_r, rd_data_nxt;
  clsm_pkg::clsm_bits_t arr_sel;
  clsm_pkg::clsm_kind_e kind;
  logic [1:0] arr_link;

  assign arr_link = 2'(addr[6:5] - 2'h2);
  assign kind = clsm_pkg::clsm_kind_e'(addr[4:3]);

  always_comb begin
    case (kind)
      clsm_pkg::CLSM_KIND_TRX: arr_sel = trx_w[arr_link];
      clsm_pkg::CLSM_KIND_RUN: arr_sel = run_w[arr_link];
      clsm_pkg::CLSM_KIND_ERR: arr_sel = err_w[arr_link];
      default: arr_sel = hlt_w[arr_link];
    endcase
  end

  // Unmapped addresses read zero; data stands only the cycle after
  always_comb begin
    rd_data_nxt = 32'h0000_0000;
    if (rd_stb) begin
      if (addr == `CLSM_ADDR_CTRL) begin
        rd_data_nxt = {24'h000000, ctrl_r};
      end else if (addr == `CLSM_ADDR_STATUS) begin
        rd_data_nxt = {24'h000000, ltrbl_r, rlink_r};
      end else if (addr == `CLSM_ADDR_PERIOD) begin
        rd_data_nxt = per_last_r;
      end else if (addr >= `CLSM_ADDR_ARR_BASE &&
                   addr <= `CLSM_ADDR_ARR_LAST) begin
        rd_data_nxt = addr[2] ? arr_sel[63:32] : arr_sel[31:0];
      end else if (addr >= `CLSM_ADDR_MASK_BASE &&
                   addr <= `CLSM_ADDR_MASK_LAST) begin
        rd_data_nxt = addr[2] ? mask_r[addr[4:3]][63:32] :
          mask_r[addr[4:3]][31:0];
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_r <= 32'h0000_0000;
    end else begin
      rd_data_r <= rd_data_nxt;
    end
  end

  assign rd_data = rd_data_r;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  property p_set_needs_enable;
    $rose(rlink_r[0]) |-> $past(link_en[0]) && $past(list_valid[0]);
  endproperty
  a_set_needs_enable: assert property (p_set_needs_enable) // [R1]
    else $error("run-link set without enable and valid list");

  property p_set_needs_entries;
    $rose(rlink_r[0]) |-> $past(all_ok[0]);
  endproperty
  a_set_needs_entries: assert property (p_set_needs_entries) // [R2]
    else $error("run-link set with an unhealthy entry");

  property p_set_needs_local;
    $rose(rlink_r[0]) |-> $past(local_run) && !$past(local_err);
  endproperty
  a_set_needs_local: assert property (p_set_needs_local) // [R3]
    else $error("run-link set while local station not running cleanly");

  property p_set_needs_chain;
    $rose(rlink_r[0]) |->
      $past(&(~mask_r[0] | g_link[0].lif.chain));
  endproperty
  a_set_needs_chain: assert property (p_set_needs_chain) // [R4]
    else $error("run-link set while a peer list is unsound");

  property p_sticky;
    rlink_r[0] && link_en[0] ##1 link_en[0] |-> rlink_r[0] [*1] ##1
      (rlink_r[0] || !$past(link_en[0]));
  endproperty
  a_sticky: assert property (p_sticky) // [R5]
    else $error("run-link dropped while enable stayed on");

  property p_trouble_inverse;
    ltrbl_r == ~rlink_r;
  endproperty
  a_trouble_inverse: assert property (p_trouble_inverse) // [R6]
    else $error("link-trouble is not the inverse of run-link");

  property p_unconfigured_clear;
    !mask_r[0][0] |=> !trx_w[0][0] && !run_w[0][0] && !hlt_w[0][0];
  endproperty
  a_unconfigured_clear: assert property (p_unconfigured_clear) // [R7]
    else $error("unconfigured entry shows a set bit");

  property p_healthy_form;
    hlt_w[0] == (trx_w[0] & run_w[0] & ~err_w[0]);
  endproperty
  a_healthy_form: assert property (p_healthy_form) // [R10]
    else $error("healthy bits disagree with their inputs");

  property p_bits_stable_without_tick;
    !tick && link_en[0] && $stable(mask_r[0]) |=>
      $stable(trx_w[0]) && $stable(run_w[0]) && $stable(err_w[0]);
  endproperty
  a_bits_stable_without_tick: assert property ( // [R13]
    p_bits_stable_without_tick)
    else $error("entry bits changed away from a period end");

  property p_disable_clears;
    !link_en[0] |=> !rlink_r[0] && hlt_w[0] == 64'h0 && trx_w[0] == 64'h0;
  endproperty
  a_disable_clears: assert property (p_disable_clears) // [R13]
    else $error("flags remain while link enable is off");

  property p_period_window;
    per_last_r[`CLSM_PER_MS_LSB +: 14] == 14'h0000 ||
      (per_last_r[`CLSM_PER_MS_LSB +: 14] >= `CLSM_PER_MIN_MS &&
       per_last_r[`CLSM_PER_MS_LSB +: 14] <= `CLSM_PER_MAX_MS);
  endproperty
  a_period_window: assert property (p_period_window) // [R12]
    else $error("stored period outside 200 ms to 10 s");

  property p_link_isolation;
    $rose(rlink_r[3]) |-> $past(link_en[3]) && $past(all_ok[3]);
  endproperty
  a_link_isolation: assert property (p_link_isolation) // [R11]
    else $error("link 3 run-link set from another link's state");

  c_rlink_set: cover property ($rose(rlink_r[0]));
  c_rlink_hold_fault: cover property (rlink_r[0] && !all_ok[0]);
  c_entry_healthy: cover property ($rose(hlt_w[0][0]));
  c_disable_drop: cover property ($fell(rlink_r[0]));
endmodule

/* File: rtl/clsm_consts.svh */
`ifndef CLSM_CONSTS_SVH
`define CLSM_CONSTS_SVH
// Behaviour
// (R1) The run-link flag may set only while link enable is on and the entry list is marked valid.
// (R2) Setting run-link also needs every configured entry to have exchanged within its period.
// (R3) Setting run-link also needs the local station to be running and free of error.
// (R4) Setting run-link also needs every peer, and the stations in its own list, running, error free and on time.
// (R5) Once set, run-link stays set whatever happens until link enable is turned off.
// (R6) Link-trouble is always the inverse of run-link.
// (R7) Each of 64 entries has an on-time bit, set when its exchange completed within its period, else clear.
// (R8) Each entry has a peer-run bit, set when its peer is in run mode, clear in stop, pause or debug.
// (R9) Each entry has a peer-error bit, set when its peer runs its program abnormally, clear otherwise.
// (R10) Each entry has a healthy bit, set only when on-time and peer-run are set and peer-error is clear.
// (R11) The whole flag set exists once per link, four links, entries indexed 0 to 63.
// (R12) An unset period means 200 ms; configured periods are held to 200 ms up to 10 s.
// (R13) Entry bits are re-evaluated at the end of each period, and all flags clear while enable is off; link-trouble is set then.

// ---------------------------------------------------------------
// Register offsets (byte addresses)
// ---------------------------------------------------------------
`define CLSM_ADDR_CTRL 8'h00
`define CLSM_ADDR_STATUS 8'h04
`define CLSM_ADDR_PERIOD 8'h08
`define CLSM_ADDR_ARR_BASE 8'h40
`define CLSM_ADDR_ARR_LAST 8'hbc
`define CLSM_ADDR_MASK_BASE 8'hc0
`define CLSM_ADDR_MASK_LAST 8'hdc

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define CLSM_CTRL_EN_LSB 0
`define CLSM_CTRL_VALID_LSB 4
`define CLSM_PER_ENTRY_LSB 0
`define CLSM_PER_LINK_LSB 6
`define CLSM_PER_MS_LSB 16

// ---------------------------------------------------------------
// Reset values and counts
// ---------------------------------------------------------------
`define CLSM_CTRL_RST 8'h00
`define CLSM_NLINK 4
`define CLSM_NENTRY 64
`define CLSM_PER_DEF_MS 14'h00c8
`define CLSM_PER_MIN_MS 14'h00c8
`define CLSM_PER_MAX_MS 14'h2710
`define CLSM_MS_NS 1000000
`define CLSM_CLK_NS 5
`define CLSM_TICK_CYC (`CLSM_MS_NS / `CLSM_CLK_NS)
`endif

/* File: rtl/clsm_pkg.sv */
package clsm_pkg;
  typedef logic [63:0] clsm_bits_t;
  typedef logic [13:0] clsm_ms_t;
  typedef enum logic [1:0] {
    CLSM_KIND_TRX,
    CLSM_KIND_RUN,
    CLSM_KIND_ERR,
    CLSM_KIND_HLT
  } clsm_kind_e;
endpackage

/* File: rtl/clsm_link_if.sv */
`timescale 1ns/1ps
interface clsm_link_if;
  logic en;
  logic evt;
  logic [5:0] eidx;
  logic done;
  logic prun;
  logic perr;
  logic pchain;
  logic pwr;
  logic [5:0] pidx;
  clsm_pkg::clsm_ms_t pms;
  clsm_pkg::clsm_bits_t mask;
  clsm_pkg::clsm_bits_t trx;
  clsm_pkg::clsm_bits_t run;
  clsm_pkg::clsm_bits_t err;
  clsm_pkg::clsm_bits_t hlt;
  clsm_pkg::clsm_bits_t chain;
  modport ctl (output en, evt, eidx, done, prun, perr, pchain, pwr, pidx,
    pms, mask, input trx, run, err, hlt, chain);
  modport lnk (input en, evt, eidx, done, prun, perr, pchain, pwr, pidx,
    pms, mask, output trx, run, err, hlt, chain);
endinterface

/* File: rtl/clsm_tick.sv */
`timescale 1ns/1ps
module clsm_tick #(
  parameter int TICK_CYC = 200000
) (
  input wire logic mclk,
  input wire logic rst_n,
  output logic tick
);
  logic [17:0] cnt_r, cnt_nxt;
  logic tick_r, tick_nxt;

  always_comb begin
    tick_nxt = 1'b0;
    cnt_nxt = cnt_r + 18'h00001;
    if (cnt_r == 18'(TICK_CYC - 1)) begin
      cnt_nxt = 18'h00000;
      tick_nxt = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 18'h00000;
      tick_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign tick = tick_r;
endmodule

/* File: rtl/clsm_link.sv */
`timescale 1ns/1ps
`include "clsm_consts.svh"
module clsm_link (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic tick,
  clsm_link_if.lnk lif
);
  clsm_pkg::clsm_ms_t per_ms [`CLSM_NENTRY];

  // Period memory; only touched by software, so no next-value split
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (int k = 0; k < `CLSM_NENTRY; k++) begin
        per_ms[k] <= `CLSM_PER_DEF_MS; // [R12]
      end
    end else if (lif.pwr) begin
      per_ms[lif.pidx] <= lif.pms;
    end
  end

  for (genvar i = 0; i < `CLSM_NENTRY; i++) begin : g_entry
    clsm_pkg::clsm_ms_t cnt_r, cnt_nxt;
    logic seen_r, seen_nxt, prun_r, prun_nxt, perr_r, perr_nxt;
    logic pch_r, pch_nxt, trx_r, trx_nxt, run_r, run_nxt;
    logic err_r, err_nxt, hlt_r, hlt_nxt, chn_r, chn_nxt;
    logic hit, seen_now;

    assign hit = lif.evt && (lif.eidx == 6'(i));
    assign seen_now = seen_r || (hit && lif.done);

    always_comb begin
      cnt_nxt = cnt_r;
      seen_nxt = seen_now;
      prun_nxt = hit ? lif.prun : prun_r;
      perr_nxt = hit ? lif.perr : perr_r;
      pch_nxt = hit ? lif.pchain : pch_r;
      trx_nxt = trx_r;
      run_nxt = run_r;
      err_nxt = err_r;
      hlt_nxt = hlt_r;
      chn_nxt = chn_r;
      if (!lif.en || !lif.mask[i]) begin
        // Unconfigured or disabled entries hold everything clear
        cnt_nxt = '0; // [R13]
        seen_nxt = 1'b0;
        prun_nxt = 1'b0;
        perr_nxt = 1'b0;
        pch_nxt = 1'b0;
        trx_nxt = 1'b0;
        run_nxt = 1'b0;
        err_nxt = 1'b0;
        hlt_nxt = 1'b0;
        chn_nxt = 1'b0;
      end else if (tick) begin
        if (cnt_r >= per_ms[i] - 14'h0001) begin
          // Period end: commit; a report in this cycle is still counted
          cnt_nxt = '0; // [R13]
          seen_nxt = 1'b0;
          trx_nxt = seen_now; // [R7]
          run_nxt = prun_nxt; // [R8]
          err_nxt = perr_nxt; // [R9]
          chn_nxt = pch_nxt; // [R4]
          hlt_nxt = seen_now && prun_nxt && !perr_nxt; // [R10]
        end else begin
          cnt_nxt = cnt_r + 14'h0001;
        end
      end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        cnt_r <= '0;
        seen_r <= 1'b0;
        prun_r <= 1'b0;
        perr_r <= 1'b0;
        pch_r <= 1'b0;
        trx_r <= 1'b0;
        run_r <= 1'b0;
        err_r <= 1'b0;
        hlt_r <= 1'b0;
        chn_r <= 1'b0;
      end else begin
        cnt_r <= cnt_nxt;
        seen_r <= seen_nxt;
        prun_r <= prun_nxt;
        perr_r <= perr_nxt;
        pch_r <= pch_nxt;
        trx_r <= trx_nxt;
        run_r <= run_nxt;
        err_r <= err_nxt;
        hlt_r <= hlt_nxt;
        chn_r <= chn_nxt;
      end
    end

    assign lif.trx[i] = trx_r;
    assign lif.run[i] = run_r;
    assign lif.err[i] = err_r;
    assign lif.hlt[i] = hlt_r;
    assign lif.chain[i] = chn_r;
  end
endmodule

/* File: dv/clsm_peer_model.sv */
`timescale 1ns/1ps
module clsm_peer_model (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic go,
  input wire logic [1:0] link,
  input wire logic [3:0] done_v,
  input wire logic [3:0] run_v,
  input wire logic [3:0] err_v,
  input wire logic [3:0] chain_v,
  output logic peer_evt,
  output logic [1:0] peer_link,
  output logic [5:0] peer_entry,
  output logic peer_done,
  output logic peer_run,
  output logic peer_err,
  output logic peer_chain_ok
);
  // ---------------------------------------------------------------
  // Report rotation
  // ---------------------------------------------------------------
  // Four stations sit on entries 0, 1, 62 and 63, so both array words
  // and the top index see traffic
  logic [1:0] gap_r;
  logic [1:0] slot_r;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      gap_r <= 2'h0;
      slot_r <= 2'h0;
      peer_evt <= 1'b0;
      peer_link <= 2'h0;
      peer_entry <= 6'h00;
      peer_done <= 1'b0;
      peer_run <= 1'b0;
      peer_err <= 1'b0;
      peer_chain_ok <= 1'b0;
    end else begin
      gap_r <= gap_r + 2'h1;
      if (go && gap_r == 2'h3) begin
        slot_r <= slot_r + 2'h1;
        peer_evt <= 1'b1;
        peer_link <= link;
        peer_entry <= {{4{slot_r[1]}}, slot_r};
        peer_done <= done_v[slot_r];
        peer_run <= run_v[slot_r];
        peer_err <= err_v[slot_r];
        peer_chain_ok <= chain_v[slot_r];
      end else begin
        // Fields are not held between reports, so stale data cannot pass
        peer_evt <= 1'b0;
        peer_link <= ~peer_link;
        peer_entry <= ~peer_entry;
        peer_done <= ~peer_done;
        peer_run <= ~peer_run;
        peer_err <= ~peer_err;
        peer_chain_ok <= ~peer_chain_ok;
      end
    end
  end
endmodule

/* File: dv/test_clsm_top.sv */
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin checked++; if ((gt) !== (ex)) begin \
  n_mismatch++; $display("BAD %s exp %h got %h", nm, ex, gt); end end
module test_clsm_top;
  localparam int TICK = 4;
  // Two default periods plus margin: any report lands in a closed period
  localparam int WT = TICK * 400 + 100;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wr_data = 32'h0;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic local_run = 1'b1;
  logic local_err = 1'b0;
  logic go = 1'b1;
  logic [1:0] plink = 2'h0;
  logic [3:0] pdone = 4'hf;
  logic [3:0] prun = 4'hf;
  logic [3:0] perr = 4'h0;
  logic [3:0] pchain = 4'hf;
  logic [31:0] rd_data;
  logic [3:0] overall_run_link_flag;
  logic [3:0] link_trouble_flag;
  logic p_evt, p_done, p_run, p_err, p_chain;
  logic [1:0] p_link;
  logic [5:0] p_entry;
  int checked = 0;
  int n_mismatch = 0;

  always #2.5 mclk = ~mclk;

  clsm_top #(.TICK_CYC(TICK)) dut_u (.mclk(mclk), .rst_n(rst_n),
    .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb),
    .rd_data(rd_data), .local_run(local_run), .local_err(local_err),
    .peer_evt(p_evt), .peer_link(p_link), .peer_entry(p_entry),
    .peer_done(p_done), .peer_run(p_run), .peer_err(p_err),
    .peer_chain_ok(p_chain), .overall_run_link_flag(overall_run_link_flag),
    .link_trouble_flag(link_trouble_flag));

  clsm_peer_model peer_u (.mclk(mclk), .rst_n(rst_n), .go(go),
    .link(plink), .done_v(pdone), .run_v(prun), .err_v(perr),
    .chain_v(pchain), .peer_evt(p_evt), .peer_link(p_link),
    .peer_entry(p_entry), .peer_done(p_done), .peer_run(p_run),
    .peer_err(p_err), .peer_chain_ok(p_chain));

  // ---------------------------------------------------------------
  // Bus tasks
  // ---------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    wr_data <= d;
    wr_stb <= 1'b1;
    @(posedge mclk);
    wr_stb <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] ex,
                        input string nm);
    @(posedge mclk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge mclk);
    rd_stb <= 1'b0;
    #1;
    `CHK(nm, ex, rd_data)
  endtask

  task automatic flags(input logic [3:0] ex);
    `CHK("run_link", ex, overall_run_link_flag)
    `CHK("trouble", ~ex, link_trouble_flag)
  endtask

  task automatic wait_per;
    repeat (WT) @(posedge mclk);
    #1;
  endtask

  task automatic good;
    @(posedge mclk);
    {pdone, prun, perr, pchain} <= 16'hff0f;
    {local_run, local_err} <= 2'h2;
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    #1;
    flags(4'h0);
    rd_chk(8'h04, 32'h000000f0, "status");
    wr(8'h10, 32'hffffffff);
    rd_chk(8'h10, 32'h0, "unmapped");
    rd_chk(8'h00, 32'h0, "ctrl");
    rd_chk(8'h58, 32'h0, "healthy");
  endtask

  task automatic t_period;
    logic [13:0] wv[4];
    logic [13:0] ev[4];
    wv = '{14'h0000, 14'h0064, 14'h3fff, 14'h01f4};
    ev = '{14'h00c8, 14'h00c8, 14'h2710, 14'h01f4};
    for (int i = 0; i < 4; i++) begin
      wr(8'h08, {2'h0, wv[i], 8'h00, 2'h1, 6'h05});
      rd_chk(8'h08, {2'h0, ev[i], 8'h00, 2'h1, 6'h05}, "period");
    end
  endtask

  task automatic t_healthy;
    wr(8'hc0, 32'h3);
    wr(8'h00, 32'h11);
    wait_per;
    rd_chk(8'h40, 32'h3, "on_time");
    rd_chk(8'h48, 32'h3, "peer_run");
    rd_chk(8'h50, 32'h0, "peer_err");
    rd_chk(8'h58, 32'h3, "healthy");
    flags(4'h1);
  endtask

  task automatic t_sticky;
    @(posedge mclk);
    {pdone, prun, perr} <= 12'hdd2;
    wait_per;
    rd_chk(8'h40, 32'h1, "on_time");
    rd_chk(8'h48, 32'h1, "peer_run");
    rd_chk(8'h50, 32'h2, "peer_err");
    rd_chk(8'h58, 32'h1, "healthy");
    rd_chk(8'h04, 32'h000000e1, "status");
  endtask

  task automatic t_disable;
    wr(8'h00, 32'h0);
    repeat (2) @(posedge mclk);
    #1;
    flags(4'h0);
    rd_chk(8'h58, 32'h0, "healthy");
  endtask

  // Each case withholds one condition; run-link must stay clear
  task automatic t_block;
    logic [7:0] ctl[5];
    logic [9:0] st[5];
    ctl = '{8'h01, 8'h11, 8'h11, 8'h11, 8'h11};
    // Missed exchange on entry 0 goes last so the on-time read sees it
    st = '{10'h2ff, 10'h3ff, 10'h0ff, 10'h2ef, 10'h2fe};
    for (int i = 0; i < 5; i++) begin
      wr(8'h00, 32'h0);
      @(posedge mclk);
      {local_run, local_err, pchain, pdone} <= st[i];
      wr(8'h00, {24'h0, ctl[i]});
      wait_per;
      flags(4'h0);
    end
    rd_chk(8'h40, 32'h2, "on_time");
    good;
    wait_per;
    flags(4'h1);
  endtask

  task automatic t_link3;
    wr(8'h00, 32'h0);
    wr(8'hdc, 32'h80000000);
    @(posedge mclk);
    plink <= 2'h3;
    wr(8'h00, 32'h88);
    wait_per;
    rd_chk(8'ha4, 32'h80000000, "on_time_hi");
    rd_chk(8'ha0, 32'h0, "on_time_lo");
    rd_chk(8'hbc, 32'h80000000, "healthy_hi");
    flags(4'h8);
    rd_chk(8'hdc, 32'h80000000, "mask_hi");
    rd_chk(8'h00, 32'h00000088, "ctrl");
  endtask

  // ---------------------------------------------------------------
  // Run
  // ---------------------------------------------------------------
  task automatic wrap_up;
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    t_reset;
    t_period;
    t_healthy;
    t_sticky;
    t_disable;
    good;
    t_block;
    t_link3;
    wrap_up;
  end

  // Scenarios need about 16000 cycles; allow well over twice that
  initial begin
    repeat (40000) @(posedge mclk);
    n_mismatch++;
    wrap_up;
  end
endmodule
